// File: common/serial_status_pkg.sv
`default_nettype none
package serial_status_pkg;
  // register byte offsets
  localparam logic [3:0] ADDR_STATUS   = 4'h0;
  localparam logic [3:0] ADDR_CONTROL  = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h8;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'hC;
  // serial_status bit positions
  localparam int B_TXE  = 7;
  localparam int B_RXF  = 6;
  localparam int B_OVR  = 5;
  localparam int B_FRM  = 4;
  localparam int B_PAR  = 3;
  localparam int B_TRANSMIT_DONE_FLAG = 2;
  localparam int B_RXMP = 1;
  localparam int B_TXMP = 0;
  // serial_control bit positions
  localparam int C_TIE  = 7;
  localparam int C_RIE  = 6;
  localparam int C_TE   = 5;
  localparam int C_RE   = 4;
  localparam int C_MULTIPROC_INTERRUPT_ENABLE = 3;
  // interrupt status / mask bit positions
  localparam int I_TXE  = 0;
  localparam int I_RXF  = 1;
  localparam int I_OVR  = 2;
  localparam int I_FRM  = 3;
  localparam int I_PAR  = 4;
  localparam int I_TRANSMIT_DONE_FLAG = 5;
  localparam int IRQ_W  = 6;
  // values after reset
  localparam logic [7:0]       STATUS_RESET  = 8'h84;
  localparam logic [7:0]       CONTROL_RESET = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_RESET     = 6'h00;
  localparam logic [1:0]       RESP_OKAY     = 2'h0;
  localparam logic [1:0]       RESP_SLVERR   = 2'h2;

  typedef struct packed {
    logic tx_buffer_empty_flag;
    logic rx_buffer_full_flag;
    logic overrun_error_flag;
    logic framing_error_flag;
    logic parity_error_flag;
    logic transmit_done_flag;
    logic rx_multiproc_bit;
    logic tx_multiproc_bit;
  } serial_status_s;

  typedef struct packed {
    logic load;
    logic last_bit;
  } tx_event_s;

  typedef struct packed {
    logic       done;
    logic       mp_bit;
    logic [1:0] stop_bits;
    logic       parity_ok;
  } rx_frame_s;
endpackage
`default_nettype wire

// File: hw/serial_status_flags.sv
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module serial_status_flags
  import serial_status_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [3:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire tx_event_s   tx_ev,
  input  wire rx_frame_s   rx_frame,
  input  wire logic        xfer_tx_write,
  input  wire logic        xfer_rx_read,
  output logic             transmit_enable,
  output logic             receive_enable,
  output logic             tx_multiproc_bit,
  output logic             rx_word_load,
  output logic             tx_interrupt_request,
  output logic             rx_interrupt_request,
  output logic             irq
);

  logic             aw_have_q;
  logic [3:0]       aw_addr_q;
  logic             w_have_q;
  logic [7:0]       w_data_q;
  logic             w_strb_q;
  logic             bvalid_q;
  logic [1:0]       bresp_q;
  logic             rvalid_q;
  logic [31:0]      rdata_q;
  logic [1:0]       rresp_q;
  logic             txe_q;
  logic             rxf_q;
  logic             ovr_q;
  logic             frm_q;
  logic             par_q;
  logic             transmit_done_flag_q;
  logic             rxmp_q;
  logic             txmp_q;
  logic [7:0]       ctrl_q;
  logic [7:3]       arm_q;
  logic [IRQ_W-1:0] irq_st_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic             rx_word_load_q;
  serial_status_s   status;
  logic [7:0]       status_v;
  logic             wr_fire;
  logic             wr_en;
  logic             wr_status;
  logic             rd_fire;
  logic             rd_status;
  logic [7:3]       clr_req;
  logic             te;
  logic             txe_clr;
  logic             rxf_clr;
  logic             rx_take;
  logic             rx_skip;
  logic             rx_norm;
  logic             ovr_set;
  logic             frm_set;
  logic             par_set;
  logic             rxf_set;
  logic             transmit_done_flag_set;
  logic             multiproc_interrupt_enable_clr;
  logic [IRQ_W-1:0] irq_ev;
  logic [7:0]       rd_mux;
  logic             rd_hit;
  logic             wr_hit;

  // ---------------- AXI4-Lite write path ----------------
  // address and data are latched separately so either may come first
  assign awready = !aw_have_q;
  assign wready  = !w_have_q;
  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
  assign wr_en   = wr_fire && w_strb_q;
  assign wr_hit  = (aw_addr_q == ADDR_STATUS) || (aw_addr_q == ADDR_CONTROL) ||
                   (aw_addr_q == ADDR_IRQ_STAT) || (aw_addr_q == ADDR_IRQ_MASK);
  assign wr_status = wr_en && (aw_addr_q == ADDR_STATUS);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 4'h0;
    end else if (awvalid && awready) begin
      aw_have_q <= 1'b1;
      aw_addr_q <= awaddr;
    end else if (wr_fire) begin
      aw_have_q <= 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      w_data_q <= 8'h00;
      w_strb_q <= 1'b0;
    end else if (wvalid && wready) begin
      w_have_q <= 1'b1;
      w_data_q <= wdata[7:0];
      w_strb_q <= wstrb[0];
    end else if (wr_fire) begin
      w_have_q <= 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign bvalid = bvalid_q;
  assign bresp  = bresp_q;
  // ---------------- AXI4-Lite read path ----------------
  assign arready   = !rvalid_q;
  assign rd_fire   = arvalid && arready;
  assign rd_status = rd_fire && (araddr == ADDR_STATUS);
  always_comb begin
    rd_mux = 8'h00;
    rd_hit = 1'b1;
    case (araddr) // an unaligned offset falls to the error answer
      ADDR_STATUS:   rd_mux = status_v;
      ADDR_CONTROL:  rd_mux = ctrl_q;
      ADDR_IRQ_STAT: rd_mux = {2'b00, irq_st_q};
      ADDR_IRQ_MASK: rd_mux = {2'b00, irq_mask_q};
      default:       rd_hit = 1'b0;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rdata_q  <= {24'h00_0000, rd_mux};
      rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end
  assign rvalid = rvalid_q;
  assign rdata  = rdata_q;
  assign rresp  = rresp_q;
  // ---------------- control register ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CONTROL_RESET;
    end else if (wr_en && (aw_addr_q == ADDR_CONTROL)) begin
      ctrl_q <= {w_data_q[7:3], 3'b000};
    end else if (multiproc_interrupt_enable_clr) begin
      ctrl_q[C_MULTIPROC_INTERRUPT_ENABLE] <= 1'b0;
    end
  end
  assign te              = ctrl_q[C_TE];
  assign transmit_enable = ctrl_q[C_TE];
  assign receive_enable  = ctrl_q[C_RE];
  // ---------------- clear arming ----------------
  // a zero only clears a flag software has actually seen at 1
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arm_q <= 5'h00;
    end else begin
      for (int i = 3; i <= 7; i++) begin
        if (!status_v[i]) begin
          arm_q[i] <= 1'b0;
        end else if (rd_status) begin
          arm_q[i] <= 1'b1;
        end else if (wr_status && !w_data_q[i]) begin
          arm_q[i] <= 1'b0;
        end
      end
    end
  end

  // a written 1 never reaches a flag
  assign clr_req = arm_q & ~w_data_q[7:3] & {5{wr_status}};
  // ---------------- transmit side ----------------
  assign txe_clr  = clr_req[B_TXE] || (xfer_tx_write && tx_interrupt_request);
  assign transmit_done_flag_set = tx_ev.last_bit && txe_q;

  // set wins over clear in every flag below
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txe_q <= STATUS_RESET[B_TXE];
    end else if (!te || tx_ev.load) begin
      txe_q <= 1'b1;
    end else if (txe_clr) begin
      txe_q <= 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      transmit_done_flag_q <= STATUS_RESET[B_TRANSMIT_DONE_FLAG];
    end else if (!te || transmit_done_flag_set) begin
      transmit_done_flag_q <= 1'b1;
    end else if (txe_clr) begin
      transmit_done_flag_q <= 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txmp_q <= STATUS_RESET[B_TXMP];
    end else if (wr_en && (aw_addr_q == ADDR_STATUS)) begin
      txmp_q <= w_data_q[B_TXMP];
    end
  end
  assign tx_multiproc_bit = txmp_q;

  // ---------------- receive side ----------------
  // frames are ignored while receive is disabled, so no receive flag can be set then
  assign rx_take  = rx_frame.done && ctrl_q[C_RE];
  assign rx_skip  = rx_take && ctrl_q[C_MULTIPROC_INTERRUPT_ENABLE] && !rx_frame.mp_bit;
  assign multiproc_interrupt_enable_clr = rx_take && ctrl_q[C_MULTIPROC_INTERRUPT_ENABLE] && rx_frame.mp_bit;
  assign rx_norm  = rx_take && !rx_skip;
  assign ovr_set  = rx_norm && rxf_q;
  // only the first stop bit is judged, even with two configured
  assign frm_set  = rx_norm && !rxf_q && !rx_frame.stop_bits[0];
  assign par_set  = rx_norm && !rxf_q && !rx_frame.parity_ok;
  assign rxf_set  = rx_norm && !rxf_q && rx_frame.stop_bits[0] && rx_frame.parity_ok;
  assign rxf_clr  = clr_req[B_RXF] || (xfer_rx_read && rx_interrupt_request);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxf_q <= STATUS_RESET[B_RXF];
    end else if (rxf_set) begin
      rxf_q <= 1'b1;
    end else if (rxf_clr) begin
      rxf_q <= 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovr_q <= STATUS_RESET[B_OVR];
    end else if (ovr_set) begin
      ovr_q <= 1'b1;
    end else if (clr_req[B_OVR]) begin
      ovr_q <= 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frm_q <= STATUS_RESET[B_FRM];
    end else if (frm_set) begin
      frm_q <= 1'b1;
    end else if (clr_req[B_FRM]) begin
      frm_q <= 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      par_q <= STATUS_RESET[B_PAR];
    end else if (par_set) begin
      par_q <= 1'b1;
    end else if (clr_req[B_PAR]) begin
      par_q <= 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxmp_q <= STATUS_RESET[B_RXMP];
    end else if (rx_take) begin
      rxmp_q <= rx_frame.mp_bit;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_word_load_q <= 1'b0;
    end else begin
      rx_word_load_q <= rxf_set;
    end
  end
  assign rx_word_load = rx_word_load_q;

  assign status   = '{txe_q, rxf_q, ovr_q, frm_q, par_q, transmit_done_flag_q, rxmp_q, txmp_q};
  assign status_v = status;

  assign tx_interrupt_request = txe_q && ctrl_q[C_TIE];
  assign rx_interrupt_request = rxf_q && ctrl_q[C_RIE];

  // ---------------- interrupt status and mask ----------------
  always_comb begin
    irq_ev         = '0;
    irq_ev[I_TXE]  = tx_ev.load && te;
    irq_ev[I_RXF]  = rxf_set;
    irq_ev[I_OVR]  = ovr_set;
    irq_ev[I_FRM]  = frm_set;
    irq_ev[I_PAR]  = par_set;
    irq_ev[I_TRANSMIT_DONE_FLAG] = transmit_done_flag_set && te;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_st_q <= IRQ_RESET;
    end else if (wr_en && (aw_addr_q == ADDR_IRQ_STAT)) begin
      irq_st_q <= (irq_st_q & ~w_data_q[IRQ_W-1:0]) | irq_ev;
    end else begin
      irq_st_q <= irq_st_q | irq_ev;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_q <= IRQ_RESET;
    end else if (wr_en && (aw_addr_q == ADDR_IRQ_MASK)) begin
      irq_mask_q <= w_data_q[IRQ_W-1:0];
    end
  end

  assign irq = |(irq_st_q & irq_mask_q);
  // ---------------- assertions ----------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_txe_off;
    !te |=> txe_q;
  endproperty
  a_txe_off: assert property (p_txe_off) else $error("empty flag low while disabled");
  // a last bit in the clearing cycle sets transmit done again, so it is left out
  property p_txe_clr;
    te && !tx_ev.load && !tx_ev.last_bit && wr_status && arm_q[B_TXE] && !w_data_q[B_TXE]
      |=> !txe_q && !transmit_done_flag_q;
  endproperty
  a_txe_clr: assert property (p_txe_clr) else $error("armed zero did not clear");
  property p_rxf_set;
    rxf_set |=> rxf_q && rx_word_load ##1 !rx_word_load;
  endproperty
  a_rxf_set: assert property (p_rxf_set) else $error("full flag or load missed");
  property p_rxf_hold;
    !receive_enable && !rxf_clr |=> rxf_q == $past(rxf_q);
  endproperty
  a_rxf_hold: assert property (p_rxf_hold) else $error("full flag moved while off");
  property p_ovr;
    rx_norm && rxf_q |=> ovr_q && (rxf_q || $past(rxf_clr));
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun not flagged");
  property p_frm;
    rx_norm && !rxf_q && !rx_frame.stop_bits[0] |=> frm_q && !rxf_q;
  endproperty
  a_frm: assert property (p_frm) else $error("framing error not flagged");
  property p_par;
    rx_norm && !rxf_q && !rx_frame.parity_ok |=> par_q && !rxf_q;
  endproperty
  a_par: assert property (p_par) else $error("parity error not flagged");
  property p_one_ignored;
    wr_status && w_data_q[B_OVR] && ovr_q |=> ovr_q;
  endproperty
  a_one_ignored: assert property (p_one_ignored) else $error("written one cleared");
  property p_unarmed;
    wr_status && !arm_q[B_FRM] && !frm_set |=> frm_q == $past(frm_q);
  endproperty
  a_unarmed: assert property (p_unarmed) else $error("unarmed zero cleared");
  property p_transmit_done_flag;
    te && tx_ev.last_bit && txe_q |=> transmit_done_flag_q;
  endproperty
  a_transmit_done_flag: assert property (p_transmit_done_flag) else $error("transmit done not set");
  property p_skip;
    rx_skip && !rxf_q && !(wr_en && (aw_addr_q == ADDR_CONTROL))
      |=> !rxf_q && !rx_word_load && ctrl_q[C_MULTIPROC_INTERRUPT_ENABLE] == $past(ctrl_q[C_MULTIPROC_INTERRUPT_ENABLE]);
  endproperty
  a_skip: assert property (p_skip) else $error("skipped frame took effect");
endmodule // serial_status_flags
`default_nettype wire

// File: dv/serial_station_model.sv
`timescale 1ns/1ps
`default_nettype none
module serial_station_model
  import serial_status_pkg::*;
(
  input  wire logic      aclk,
  input  wire logic      tx_multiproc_bit,
  output var  tx_event_s tx_ev,
  output var  rx_frame_s rx_frame,
  output var  logic      seen_mp
);
  initial begin
    tx_ev    = '0;
    rx_frame = '0;
    seen_mp  = 1'b0;
  end

  // frame fields mean nothing outside done, so they show the inverse there
  task automatic send_frame(input logic mp, input logic [1:0] stop, input logic par);
    @(posedge aclk);
    rx_frame <= '{1'b1, mp, stop, par};
    @(posedge aclk);
    rx_frame <= '{1'b0, ~mp, ~stop, ~par};
  endtask

  task automatic shift_word(input logic last);
    @(posedge aclk);
    tx_ev <= '{1'b1, 1'b0};
    @(posedge aclk);
    tx_ev   <= '{1'b0, last};
    seen_mp <= tx_multiproc_bit;
    @(posedge aclk);
    tx_ev <= '0;
  endtask
endmodule // serial_station_model
`default_nettype wire

// File: dv/tb_serial_status_flags.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %0t: got %h want %h", $time, (g), (e)); end end
module tb_serial_status_flags
  import serial_status_pkg::*;
;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, xfer_tx_write, xfer_rx_read;
  logic        transmit_enable, receive_enable, tx_multiproc_bit, rx_word_load;
  logic        tx_interrupt_request, rx_interrupt_request, irq, seen_mp;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  tx_event_s   tx_ev;
  rx_frame_s   rx_frame;
  int          n_fail, checked;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [1:0] nfr;
    logic       mp;
    logic [1:0] stop;
    logic       par;
    logic [7:0] st;
    logic [7:0] ctl;
  } row_s;
  // control, frames, mp bit, stop bits, parity ok -> status, control after
  row_s rows [11] = '{
    '{8'h10, 2'h1, 1'h0, 2'h3, 1'h1, 8'hC4, 8'h10},
    '{8'h10, 2'h1, 1'h1, 2'h3, 1'h1, 8'hC6, 8'h10},
    '{8'h10, 2'h1, 1'h0, 2'h2, 1'h1, 8'h94, 8'h10},
    '{8'h10, 2'h1, 1'h0, 2'h1, 1'h1, 8'hC4, 8'h10},
    '{8'h10, 2'h1, 1'h0, 2'h3, 1'h0, 8'h8C, 8'h10},
    '{8'h10, 2'h2, 1'h0, 2'h3, 1'h1, 8'hE4, 8'h10},
    '{8'h10, 2'h1, 1'h0, 2'h0, 1'h0, 8'h9C, 8'h10},
    '{8'h00, 2'h1, 1'h1, 2'h3, 1'h1, 8'h84, 8'h00},
    '{8'h18, 2'h1, 1'h0, 2'h3, 1'h1, 8'h84, 8'h18},
    '{8'h18, 2'h1, 1'h0, 2'h0, 1'h1, 8'h84, 8'h18},
    '{8'h18, 2'h1, 1'h1, 2'h3, 1'h1, 8'hC6, 8'h10}
  };

  serial_status_flags uut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .tx_ev(tx_ev), .rx_frame(rx_frame), .xfer_tx_write(xfer_tx_write),
    .xfer_rx_read(xfer_rx_read), .transmit_enable(transmit_enable),
    .receive_enable(receive_enable), .tx_multiproc_bit(tx_multiproc_bit),
    .rx_word_load(rx_word_load), .tx_interrupt_request(tx_interrupt_request),
    .rx_interrupt_request(rx_interrupt_request), .irq(irq)
  );

  serial_station_model u_peer (
    .aclk(aclk), .tx_multiproc_bit(tx_multiproc_bit), .tx_ev(tx_ev),
    .rx_frame(rx_frame), .seen_mp(seen_mp)
  );

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic hang();
    n_fail++;
    $display("BAD %0t: bus wait ran out", $time);
    test_done();
  endtask

  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
    int   n;
    logic aw_ok, w_ok, b_ok;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    b_ok  = 1'b0;
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= {24'h000000, d};
    wstrb   <= 4'hF;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 64 && !b_ok; n++) begin
      @(posedge aclk);
      if (!aw_ok && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
      if (aw_ok && w_ok && bvalid) begin
        b_ok = 1'b1;
        bready <= 1'b0;
        `CHK(bresp, er)
      end
    end
    // let an edge pass so the next call never re-raises bready in this step
    @(posedge aclk);
    if (!b_ok) hang();
  endtask

  // compares the whole word: upper bits must read zero, low byte under mask m
  task automatic rchk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e,
                      input logic [1:0] er);
    int   n;
    logic ar_ok, r_ok;
    ar_ok = 1'b0;
    r_ok  = 1'b0;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 64 && !r_ok; n++) begin
      @(posedge aclk);
      if (ar_ok && rvalid) begin
        r_ok = 1'b1;
        rready <= 1'b0;
        `CHK(rdata & {24'hFFFFFF, m}, {24'h000000, e})
        `CHK(rresp, er)
      end
      if (!ar_ok && arready) begin
        ar_ok = 1'b1;
        arvalid <= 1'b0;
      end
    end
    @(posedge aclk);
    if (!r_ok) hang();
  endtask

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {xfer_tx_write, xfer_rx_read} = '0;
    awaddr = 4'h0;
    araddr = 4'h0;
    wstrb  = 4'h0;
    wdata  = 32'h00000000;
    n_fail  = 0;
    checked = 0;
    do_reset();
    rchk(ADDR_STATUS, 8'hFF, STATUS_RESET, RESP_OKAY);
    rchk(ADDR_CONTROL, 8'hFF, CONTROL_RESET, RESP_OKAY);
    rchk(ADDR_IRQ_STAT, 8'hFF, 8'h00, RESP_OKAY);
    rchk(ADDR_IRQ_MASK, 8'hFF, 8'h00, RESP_OKAY);
    rchk(4'h2, 8'hFF, 8'h00, RESP_SLVERR);
    wr(4'h2, 8'hFF, RESP_SLVERR);
    $display("test reset done");
    foreach (rows[i]) begin
      do_reset();
      wr(ADDR_CONTROL, rows[i].ctrl, RESP_OKAY);
      repeat (rows[i].nfr) u_peer.send_frame(rows[i].mp, rows[i].stop, rows[i].par);
      rchk(ADDR_STATUS, 8'hFF, rows[i].st, RESP_OKAY);
      rchk(ADDR_CONTROL, 8'hFF, rows[i].ctl, RESP_OKAY);
    end
    $display("test table done");
    // a zero written before any read must not clear
    do_reset();
    wr(ADDR_CONTROL, 8'h10, RESP_OKAY);
    repeat (2) u_peer.send_frame(1'b0, 2'h3, 1'b1);
    wr(ADDR_STATUS, 8'h00, RESP_OKAY);
    rchk(ADDR_STATUS, 8'hFF, 8'hE4, RESP_OKAY);
    wr(ADDR_STATUS, 8'hFE, RESP_OKAY);
    wr(ADDR_STATUS, 8'hDE, RESP_OKAY);
    rchk(ADDR_STATUS, 8'hFF, 8'hC4, RESP_OKAY);
    wr(ADDR_STATUS, 8'hBE, RESP_OKAY);
    rchk(ADDR_STATUS, 8'hFF, 8'h84, RESP_OKAY);
    u_peer.send_frame(1'b0, 2'h0, 1'b0);
    rchk(ADDR_STATUS, 8'hFF, 8'h9C, RESP_OKAY);
    wr(ADDR_STATUS, 8'hE6, RESP_OKAY);
    rchk(ADDR_STATUS, 8'hFF, 8'h84, RESP_OKAY);
    $display("test clear done");
    do_reset();
    wr(ADDR_CONTROL, 8'hA0, RESP_OKAY);
    #1;
    `CHK(transmit_enable, 1'b1)
    `CHK(tx_interrupt_request, 1'b1)
    rchk(ADDR_STATUS, 8'hFF, 8'h84, RESP_OKAY);
    wr(ADDR_STATUS, 8'h7F, RESP_OKAY);
    rchk(ADDR_STATUS, 8'hFF, 8'h01, RESP_OKAY);
    #1;
    `CHK(tx_interrupt_request, 1'b0)
    u_peer.shift_word(1'b1);
    rchk(ADDR_STATUS, 8'hFF, 8'h85, RESP_OKAY);
    `CHK(seen_mp, 1'b1)
    @(posedge aclk);
    xfer_tx_write <= 1'b1;
    @(posedge aclk);
    xfer_tx_write <= 1'b0;
    rchk(ADDR_STATUS, 8'hFF, 8'h01, RESP_OKAY);
    $display("test transmit done");
    do_reset();
    wr(ADDR_IRQ_MASK, 8'h02, RESP_OKAY);
    wr(ADDR_CONTROL, 8'h50, RESP_OKAY);
    u_peer.send_frame(1'b0, 2'h3, 1'b1);
    #1;
    `CHK(receive_enable, 1'b1)
    `CHK(rx_word_load, 1'b1)
    `CHK(rx_interrupt_request, 1'b1)
    `CHK(irq, 1'b1)
    rchk(ADDR_IRQ_STAT, 8'h02, 8'h02, RESP_OKAY);
    wr(ADDR_IRQ_MASK, 8'h00, RESP_OKAY);
    #1;
    `CHK(irq, 1'b0)
    wr(ADDR_IRQ_MASK, 8'h02, RESP_OKAY);
    wr(ADDR_IRQ_STAT, 8'h02, RESP_OKAY);
    #1;
    `CHK(irq, 1'b0)
    rchk(ADDR_IRQ_STAT, 8'h02, 8'h00, RESP_OKAY);
    wr(ADDR_CONTROL, 8'h40, RESP_OKAY);
    rchk(ADDR_STATUS, 8'hFF, 8'hC4, RESP_OKAY);
    @(posedge aclk);
    xfer_rx_read <= 1'b1;
    @(posedge aclk);
    xfer_rx_read <= 1'b0;
    rchk(ADDR_STATUS, 8'hFF, 8'h84, RESP_OKAY);
    #1;
    `CHK(rx_interrupt_request, 1'b0)
    $display("test receive done");
    test_done();
  end
endmodule // tb_serial_status_flags
`default_nettype wire
